// >>> dv/frc_flash_model.sv
// Behavioural model of the flash device behind the host controller
`timescale 1ns/100ps
module frc_flash_model (
  input wire logic               clock,       // Bench clock
  input wire frc_pkg::frc_pins_t pins,        // Control and address pins
  input wire logic [15:0]        dq_out,      // Data from host
  input wire logic               make_busy,   // Starts a long operation
  input wire logic [31:0]        busy_len,    // Internal reset cycles
  output logic [15:0]            dq_in,       // Data to host
  output logic                   ready_busy_n // Driven low while busy, high otherwise
);
  logic [63:0] prot = 64'h0;
  logic [15:0] mem [int];
  logic [15:0] last = 16'h0;
  logic [15:0] val;
  logic        busy = 1'b0;
  logic        in_rst = 1'b0;
  logic        armed = 1'b0;
  realtime     fall_t = 0.0;
  int          cnt = 0;
  // A strobe fall arms the next rise; nothing is armed at power-up
  always @(negedge pins.write_n) begin
    fall_t = $realtime;
    armed = 1'b1;
  end
  // Strobe rise ends a protect, an unprotect or a data write
  always @(posedge pins.write_n) begin
    if (!armed || $realtime - fall_t < 5.0) armed = 1'b0;
    else if (pins.addr9_elevated && pins.out_en_elevated) begin
      if (pins.addr[6]) prot = 64'h0;
      else prot[pins.addr[17:12]] = 1'b1;
    end else if (!pins.chip_sel_n && pins.reset_n && !busy) begin
      if (!prot[pins.addr[17:12]] || pins.reset_elevated)
        mem[pins.addr] = pins.word_mode ? dq_out : {8'h00, dq_out[7:0]};
    end
  end
  // Drives only when selected; released lines invert every cycle
  always @* begin
    if (pins.addr9_elevated) val = {15'h0, prot[pins.addr[17:12]]};
    else val = mem.exists(pins.addr) ? mem[pins.addr] : 16'hFFFF;
    dq_in = ~last;
    if (!pins.chip_sel_n && !pins.out_en_n && pins.write_n && pins.reset_n)
      dq_in = pins.word_mode ? val : {~last[15:8], val[7:0]};
  end
  // A reset during a long operation keeps ready low for busy_len cycles
  always @(posedge clock) begin
    last <= dq_in;
    if (make_busy) busy <= 1'b1;
    if (busy && !pins.reset_n && !in_rst) begin
      in_rst <= 1'b1;
      cnt <= busy_len;
    end
    if (in_rst) cnt <= cnt - 1;
    if (in_rst && cnt == 1) begin
      busy <= 1'b0;
      in_rst <= 1'b0;
    end
  end
  assign ready_busy_n = !busy;
endmodule : frc_flash_model

// >>> dv/frc_host_props.sv
// Checker for the flash host controller pins and data drive enables
`timescale 1ns/100ps
module frc_host_props #(
  parameter int RST_BUSY_CYC     = 50,
  parameter int PROT_PULSE_CYC   = 40,
  parameter int UNPROT_PULSE_CYC = 60
) (
  input wire logic               clock,           // Clock
  input wire logic               reset,           // Async reset
  input wire logic [3:0]         avs_address,     // Word address
  input wire logic               avs_read,        // Read request
  input wire logic               avs_write,       // Write request
  input wire logic [31:0]        avs_writedata,   // Write data
  input wire logic [31:0]        avs_readdata,    // Read data
  input wire logic               avs_waitrequest, // Stall
  input wire frc_pkg::frc_pins_t flash_pins,      // Flash pins
  input wire logic [15:0]        dq_out,          // Data to flash
  input wire logic [15:0]        dq_oe,           // Data enables
  input wire logic [15:0]        dq_in,           // Data from flash
  input wire logic               ready_busy_n     // Ready
);
  logic [23:0] low_cnt_reg;
  logic [23:0] low_cnt_next;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // Counts cycles with the write strobe low
  always_comb low_cnt_next = flash_pins.write_n ? 24'h0 : low_cnt_reg + 24'h1;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) low_cnt_reg <= 24'h0;
    else low_cnt_reg <= low_cnt_next;
  end
  sequence strobe_end; $rose(flash_pins.write_n); endsequence
  sequence prot_sel; flash_pins.out_en_elevated && !flash_pins.addr[6]; endsequence
  sequence unprot_sel; flash_pins.out_en_elevated && flash_pins.addr[6]; endsequence
  rst_float_a: assert property (!flash_pins.reset_n |-> dq_oe == 16'h0000)
    else $error("data driven while flash reset low");
  rst_recover_a: assert property ($fell(flash_pins.out_en_n) |-> $past(flash_pins.reset_n, 13))
    else $error("read enabled too soon after flash reset");
  sel_entry_a: assert property (flash_pins.out_en_elevated |-> flash_pins.addr9_elevated
    && !flash_pins.chip_sel_n && !flash_pins.addr[0] && flash_pins.addr[1]) else $error("bad entry");
  prot_width_a: assert property (strobe_end ##0 prot_sel |-> low_cnt_reg == PROT_PULSE_CYC)
    else $error("protect strobe width wrong");
  unprot_width_a: assert property (strobe_end ##0 unprot_sel |-> low_cnt_reg == UNPROT_PULSE_CYC)
    else $error("unprotect strobe width wrong");
  pulse_stable_a: assert property (!flash_pins.write_n && !$past(flash_pins.write_n)
    |-> $stable(flash_pins.addr) && $stable(flash_pins.out_en_elevated)) else $error("unstable");
  verify_lvls_a: assert property (flash_pins.addr9_elevated && !flash_pins.out_en_n
    && !flash_pins.out_en_elevated |-> flash_pins.write_n && !flash_pins.chip_sel_n)
    else $error("verify levels wrong");
  dq_width_a: assert property (dq_oe != 16'h0 |-> dq_oe == (flash_pins.word_mode ? 16'hFFFF
    : 16'h00FF)) else $error("data enables do not match width");
endmodule : frc_host_props

// >>> dv/frc_host_tb.sv
// Self-checking bench for the flash host controller
`timescale 1ns/100ps
module frc_host_tb;
  localparam int BL = 200;
  logic               clock = 1'b0;
  logic               reset = 1'b1;
  logic [3:0]         avs_address = 4'h0;
  logic               avs_read = 1'b0;
  logic               avs_write = 1'b0;
  logic [31:0]        avs_writedata = 32'h0;
  logic [31:0]        avs_readdata;
  logic               avs_waitrequest;
  frc_pkg::frc_pins_t flash_pins;
  logic [15:0]        dq_out, dq_oe, dq_in;
  logic               ready_busy_n;
  logic               make_busy = 1'b0;
  logic [63:0]        exp_q[$];
  logic [31:0]        seed = 32'h6489;
  int                 fail_count = 0;
  int                 n_checks = 0;
  int                 cyc = 0;
  frc_host #(.RST_BUSY_CYC(300), .PROT_PULSE_CYC(40), .UNPROT_PULSE_CYC(60)) frc_host_i (
    .clock(clock), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .flash_pins(flash_pins), .dq_out(dq_out),
    .dq_oe(dq_oe), .dq_in(dq_in), .ready_busy_n(ready_busy_n));
  frc_flash_model frc_flash_model_i (.clock(clock), .pins(flash_pins), .dq_out(dq_out),
    .make_busy(make_busy), .busy_len(BL), .dq_in(dq_in), .ready_busy_n(ready_busy_n));
  always #2 clock = ~clock;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic results();
    if (fail_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  // One bus transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    exp_q.push_back({m, e & m});
    bus(1'b0, a, 32'h0);
  endtask : rd
  // Waits for idle, runs one flash command to completion, then reads back if masked
  task automatic fl(input frc_pkg::frc_cmd_t c, input logic [17:0] a, input logic [15:0] d,
                    input logic [31:0] m, input logic [31:0] e);
    do rd(frc_pkg::REG_STATUS, 32'h0, 32'h0);
    while (avs_readdata[frc_pkg::ST_BUSY] !== 1'b0);
    bus(1'b1, frc_pkg::REG_ADDR, 32'(a));
    bus(1'b1, frc_pkg::REG_WDATA, 32'(d));
    bus(1'b1, frc_pkg::REG_CTRL, 32'h10 | 32'(c));
    do rd(frc_pkg::REG_STATUS, 32'h0, 32'h0);
    while (avs_readdata[frc_pkg::ST_DONE] !== 1'b1 || avs_readdata[frc_pkg::ST_BUSY] !== 1'b0);
    if (m != 32'h0) rd(frc_pkg::REG_RDATA, m, e);
  endtask : fl
  // Takes the oldest note whenever a read is answered
  always @(posedge clock) begin
    logic [63:0] e;
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e[63:32] != 32'h0)
        check("readdata", avs_readdata & e[63:32], e[31:0]);
    end
  end
  // Cuts a hang short
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      results();
    end
  end
  initial begin
    logic [17:0] a;
    logic [15:0] v;
    int t;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    a = 18'(rnd());
    v = 16'(rnd());
    rd(frc_pkg::REG_CFG, 32'h7, 32'h1); // CFG reset value
    bus(1'b1, 4'hF, rnd());
    rd(4'hF, 32'hFFFFFFFF, frc_pkg::UNMAPPED_DATA); // Unmapped place reads zero
    fl(frc_pkg::FRC_CMD_PROT_VERIFY, a, 16'h0, 32'hFF, 32'h0);
    fl(frc_pkg::FRC_CMD_WRITE, a, v, 32'h0, 32'h0);
    fl(frc_pkg::FRC_CMD_READ, a, 16'h0, 32'hFFFF, 32'(v));
    fl(frc_pkg::FRC_CMD_PROTECT, a, 16'h0, 32'h0, 32'h0);
    fl(frc_pkg::FRC_CMD_PROT_VERIFY, a, 16'h0, 32'hFF, 32'h1);
    rd(frc_pkg::REG_STATUS, 32'h8, 32'h8);
    fl(frc_pkg::FRC_CMD_UNPROT_VERIFY, a, 16'h0, 32'hFF, 32'h1);
    fl(frc_pkg::FRC_CMD_WRITE, a, ~v, 32'h0, 32'h0);
    fl(frc_pkg::FRC_CMD_READ, a, 16'h0, 32'hFFFF, 32'(v));
    bus(1'b1, frc_pkg::REG_CFG, 32'h5);
    fl(frc_pkg::FRC_CMD_WRITE, a, ~v, 32'h0, 32'h0);
    bus(1'b1, frc_pkg::REG_CFG, 32'h1);
    fl(frc_pkg::FRC_CMD_READ, a, 16'h0, 32'hFFFF, 32'(~v));
    for (int s = 0; s < 64; s++) fl(frc_pkg::FRC_CMD_PROTECT, {6'(s), 12'h0}, 16'h0, 32'h0, 32'h0);
    fl(frc_pkg::FRC_CMD_UNPROTECT, a, 16'h0, 32'h0, 32'h0);
    fl(frc_pkg::FRC_CMD_UNPROT_VERIFY, a ^ 18'h3F000, 16'h0, 32'hFF, 32'h0);
    bus(1'b1, frc_pkg::REG_CFG, 32'h0);
    fl(frc_pkg::FRC_CMD_WRITE, a ^ 18'h1, v, 32'h0, 32'h0);
    fl(frc_pkg::FRC_CMD_READ, a ^ 18'h1, 16'h0, 32'hFF, 32'(v[7:0]));
    bus(1'b1, frc_pkg::REG_CFG, 32'h3);
    repeat (5) @(posedge clock);
    check("reset_n", 32'(flash_pins.reset_n), 32'h0);
    bus(1'b1, frc_pkg::REG_CFG, 32'h1);
    fl(frc_pkg::FRC_CMD_RESET, a, 16'h0, 32'h0, 32'h0);
    fl(frc_pkg::FRC_CMD_READ, a, 16'h0, 32'hFFFF, 32'(~v));
    make_busy <= 1'b1;
    @(posedge clock);
    make_busy <= 1'b0;
    t = cyc;
    fl(frc_pkg::FRC_CMD_RESET_LONG, a, 16'h0, 32'h0, 32'h0);
    check("reset_wait", 32'(cyc - t >= BL), 32'h1);
    rd(frc_pkg::REG_STATUS, 32'h4, 32'h4);
    fl(frc_pkg::FRC_CMD_WRITE, a, v, 32'h0, 32'h0);
    fl(frc_pkg::FRC_CMD_READ, a, 16'h0, 32'hFFFF, 32'(v));
    repeat (4) @(posedge clock);
    results();
  end
endmodule : frc_host_tb
bind frc_host frc_host_props #(.RST_BUSY_CYC(RST_BUSY_CYC), .PROT_PULSE_CYC(PROT_PULSE_CYC),
  .UNPROT_PULSE_CYC(UNPROT_PULSE_CYC)) frc_host_props_i (.clock(clock), .reset(reset),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .flash_pins(flash_pins), .dq_out(dq_out),
  .dq_oe(dq_oe), .dq_in(dq_in), .ready_busy_n(ready_busy_n));

// >>> hw/frc_host.sv
// Host controller that drives the flash through its pins
`timescale 1ns/100ps
module frc_host #(
  parameter int RST_BUSY_CYC     = frc_pkg::RST_BUSY_CYC,
  parameter int PROT_PULSE_CYC   = frc_pkg::PROT_PULSE_CYC,
  parameter int UNPROT_PULSE_CYC = frc_pkg::UNPROT_PULSE_CYC
) (
  input  wire logic              clock,           // 250 MHz clock
  input  wire logic              reset,           // Async reset, active high
  input  wire logic [3:0]        avs_address,     // Word address
  input  wire logic              avs_read,        // Read request
  input  wire logic              avs_write,       // Write request
  input  wire logic [31:0]       avs_writedata,   // Write data
  output logic      [31:0]       avs_readdata,    // Read data
  output logic                   avs_waitrequest, // Stall
  output frc_pkg::frc_pins_t     flash_pins,      // Flash control/address pins
  output logic      [15:0]       dq_out,          // Data to flash
  output logic      [15:0]       dq_oe,           // Data drive enables
  input  wire logic [15:0]       dq_in,           // Data from flash
  input  wire logic              ready_busy_n     // Open-drain ready
);
  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [16:0] sync1_reg, sync2_reg;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sync1_reg <= 17'h1FFFF;
      sync2_reg <= 17'h1FFFF;
    end else begin
      sync1_reg <= {ready_busy_n, dq_in};
      sync2_reg <= sync1_reg;
    end
  end
  logic        rdy_s;
  logic [15:0] dq_s;
  assign rdy_s = sync2_reg[16];
  assign dq_s  = sync2_reg[15:0];

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    FRC_IDLE, FRC_SETUP, FRC_PULSE, FRC_HOLD, FRC_SAMPLE, FRC_RST_LOW,
    FRC_RST_WAIT, FRC_RECOVER, FRC_PDOWN
  } frc_state_t;

  frc_state_t          state_reg, state_next;
  logic [frc_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  frc_pkg::frc_cmd_t   cmd_reg, cmd_next;
  logic [17:0]         addr_reg, addr_next;
  logic [15:0]         wdata_reg, wdata_next;
  logic [15:0]         rdata_reg, rdata_next;
  logic [2:0]          cfg_reg, cfg_next;
  logic                done_reg, done_next;
  logic                prot_reg, prot_next;
  frc_pkg::frc_pins_t  pins_reg, pins_next;
  logic                drive_reg, drive_next;
  logic [31:0]         rd_reg, rd_next;
  logic                ack_reg, ack_next;

  logic busy;
  logic acc;
  assign busy = (state_reg != FRC_IDLE) && (state_reg != FRC_PDOWN);
  assign acc  = (avs_read | avs_write) & ~ack_reg;

  // Pin levels for the protect modes
  function automatic frc_pkg::frc_pins_t mode_pins(input frc_pkg::frc_cmd_t c,
                                                   input logic [17:0] a,
                                                   input logic [2:0] cfg);
    frc_pkg::frc_pins_t p;
    p = '0;
    p.chip_sel_n     = 1'b0;
    p.out_en_n       = 1'b1;
    p.write_n        = 1'b1;
    p.reset_n        = 1'b1;
    p.word_mode      = cfg[frc_pkg::CFG_WORD];
    p.reset_elevated = cfg[frc_pkg::CFG_TEMP_UNP];
    p.addr           = a;
    case (c)
      frc_pkg::FRC_CMD_PROTECT, frc_pkg::FRC_CMD_UNPROTECT: begin
        p.addr9_elevated  = 1'b1;
        p.out_en_elevated = 1'b1;
        p.addr[frc_pkg::A0_BIT] = 1'b0;
        p.addr[frc_pkg::A1_BIT] = 1'b1;
        p.addr[frc_pkg::A6_BIT] = (c == frc_pkg::FRC_CMD_UNPROTECT);
      end
      frc_pkg::FRC_CMD_PROT_VERIFY, frc_pkg::FRC_CMD_UNPROT_VERIFY: begin
        p.addr9_elevated = 1'b1;
        p.addr[frc_pkg::A0_BIT] = 1'b0;
        p.addr[frc_pkg::A1_BIT] = 1'b1;
        p.addr[frc_pkg::A6_BIT] = (c == frc_pkg::FRC_CMD_UNPROT_VERIFY);
      end
      default: begin
      end
    endcase
    return p;
  endfunction

  // Next state of sequencer and register file
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    cmd_next   = cmd_reg;
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    cfg_next   = cfg_reg;
    done_next  = done_reg;
    prot_next  = prot_reg;
    pins_next  = pins_reg;
    drive_next = drive_reg;
    rd_next    = rd_reg;
    ack_next   = acc;
    // Writes land at the edge that sees waitrequest low; reads load a cycle early
    if (avs_write && ack_reg) begin
      case (avs_address)
        frc_pkg::REG_CTRL: begin
          // Refused in power-down as well, which would skip the recovery wait
          if (avs_writedata[frc_pkg::CTRL_START] && state_reg == FRC_IDLE) begin
            cmd_next   = frc_pkg::frc_cmd_t'(avs_writedata[3:0]);
            done_next  = 1'b0;
            cnt_next   = '0;
            state_next = FRC_SETUP;
          end
        end
        frc_pkg::REG_ADDR:  addr_next  = avs_writedata[17:0];
        frc_pkg::REG_WDATA: wdata_next = avs_writedata[15:0];
        frc_pkg::REG_CFG:   cfg_next   = avs_writedata[2:0];
        default: begin
        end
      endcase
    end
    if (acc && avs_read) begin
      case (avs_address)
        frc_pkg::REG_ADDR:   rd_next = {14'h0000, addr_reg};
        frc_pkg::REG_WDATA:  rd_next = {16'h0000, wdata_reg};
        frc_pkg::REG_STATUS: rd_next = {28'h0000000, prot_reg, rdy_s, done_reg, busy};
        frc_pkg::REG_RDATA:  rd_next = {16'h0000, rdata_reg};
        frc_pkg::REG_CFG:    rd_next = {29'h00000000, cfg_reg};
        default:             rd_next = frc_pkg::UNMAPPED_DATA;
      endcase
    end
    // Pin sequencing
    case (state_reg)
      FRC_IDLE: begin
        pins_next  = mode_pins(frc_pkg::FRC_CMD_READ, addr_reg, cfg_reg);
        pins_next.chip_sel_n = 1'b1;
        drive_next = 1'b0;
        if (cfg_reg[frc_pkg::CFG_PDOWN]) begin
          state_next = FRC_PDOWN;
        end
      end
      FRC_PDOWN: begin
        pins_next.reset_n = 1'b0;
        drive_next = 1'b0;
        if (!cfg_reg[frc_pkg::CFG_PDOWN]) begin
          cnt_next   = '0;
          state_next = FRC_RST_WAIT;
        end
      end
      FRC_SETUP: begin
        cnt_next = cnt_reg + 1'b1;
        if (cmd_reg == frc_pkg::FRC_CMD_RESET || cmd_reg == frc_pkg::FRC_CMD_RESET_LONG) begin
          pins_next.reset_n    = 1'b0;
          pins_next.chip_sel_n = 1'b1;
          drive_next = 1'b0;
          cnt_next   = '0;
          state_next = FRC_RST_LOW;
        end else begin
          pins_next  = mode_pins(cmd_reg, addr_reg, cfg_reg);
          // Mode pins keep their forced address bits in byte mode too
          drive_next = (cmd_reg == frc_pkg::FRC_CMD_WRITE);
          if (cnt_reg >= frc_pkg::CNT_W'(frc_pkg::SETUP_CYC)) begin
            cnt_next   = '0;
            state_next = FRC_PULSE;
          end
        end
      end
      FRC_PULSE: begin
        cnt_next = cnt_reg + 1'b1;
        case (cmd_reg)
          frc_pkg::FRC_CMD_WRITE: begin
            pins_next.write_n = 1'b0;                        // width >> 5ns
            if (cnt_reg >= frc_pkg::CNT_W'(frc_pkg::SETUP_CYC)) begin
              cnt_next = '0;
              state_next = FRC_HOLD;
            end
          end
          frc_pkg::FRC_CMD_PROTECT: begin
            pins_next.write_n = 1'b0;
            if (cnt_reg >= frc_pkg::CNT_W'(PROT_PULSE_CYC - 1)) begin
              cnt_next = '0;
              state_next = FRC_HOLD;
            end
          end
          frc_pkg::FRC_CMD_UNPROTECT: begin
            pins_next.write_n = 1'b0;
            if (cnt_reg >= frc_pkg::CNT_W'(UNPROT_PULSE_CYC - 1)) begin
              cnt_next = '0;
              state_next = FRC_HOLD;
            end
          end
          default: begin
            pins_next.out_en_n = 1'b0;                       // Read or verify
            if (cnt_reg >= frc_pkg::CNT_W'(frc_pkg::ACCESS_CYC + 2)) begin
              state_next = FRC_SAMPLE;
            end
          end
        endcase
      end
      FRC_SAMPLE: begin
        // Word mode: all 16 lines; byte mode: low 8 only
        rdata_next = cfg_reg[frc_pkg::CFG_WORD] ? dq_s : {8'h00, dq_s[7:0]};
        prot_next  = dq_s[0];
        pins_next.out_en_n = 1'b1;
        cnt_next   = '0;
        state_next = FRC_HOLD;
      end
      FRC_HOLD: begin
        pins_next.write_n = 1'b1;
        pins_next.out_en_n = 1'b1;
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg >= frc_pkg::CNT_W'(frc_pkg::SETUP_CYC)) begin
          pins_next  = mode_pins(frc_pkg::FRC_CMD_READ, addr_reg, cfg_reg);
          pins_next.chip_sel_n = 1'b1;
          drive_next = 1'b0;
          done_next  = 1'b1;
          state_next = FRC_IDLE;
        end
      end
      FRC_RST_LOW: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg >= frc_pkg::CNT_W'(frc_pkg::RST_PULSE_CYC - 1)) begin
          pins_next.reset_n = 1'b1;
          cnt_next   = '0;
          state_next = FRC_RST_WAIT;
        end
      end
      FRC_RST_WAIT: begin
        pins_next.reset_n = 1'b1;
        cnt_next = cnt_reg + 1'b1;
        // After a cut program/erase, wait for ready, or RST_BUSY_CYC cycles at most, before any rewrite
        if (cmd_reg != frc_pkg::FRC_CMD_RESET_LONG ||
            (rdy_s && cnt_reg > frc_pkg::CNT_W'(2)) ||
            cnt_reg >= frc_pkg::CNT_W'(RST_BUSY_CYC - 1)) begin
          cnt_next   = '0;
          state_next = FRC_RECOVER;
        end
      end
      FRC_RECOVER: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg >= frc_pkg::CNT_W'(frc_pkg::RST_RECOVER_CYC - 1)) begin
          done_next  = 1'b1;
          state_next = FRC_IDLE;
        end
      end
      default: state_next = FRC_IDLE;
    endcase
  end

  // Registers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_reg <= FRC_IDLE;
      cnt_reg   <= '0;
      cmd_reg   <= frc_pkg::FRC_CMD_READ;
      addr_reg  <= 18'h00000;
      wdata_reg <= 16'h0000;
      rdata_reg <= 16'h0000;
      cfg_reg   <= 3'h1;
      done_reg  <= 1'b0;
      prot_reg  <= 1'b0;
      pins_reg  <= '{chip_sel_n: 1'b1, out_en_n: 1'b1, write_n: 1'b1, reset_n: 1'b1,
                     word_mode: 1'b1, default: '0};
      drive_reg <= 1'b0;
      rd_reg    <= 32'h0000_0000;
      ack_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      cmd_reg   <= cmd_next;
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      cfg_reg   <= cfg_next;
      done_reg  <= done_next;
      prot_reg  <= prot_next;
      pins_reg  <= pins_next;
      drive_reg <= drive_next;
      rd_reg    <= rd_next;
      ack_reg   <= ack_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign flash_pins      = pins_reg;
  assign dq_out          = wdata_reg;
  assign dq_oe           = drive_reg ? (cfg_reg[frc_pkg::CFG_WORD] ? 16'hFFFF : 16'h00FF)
                                     : 16'h0000;
  assign avs_readdata    = rd_reg;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
endmodule : frc_host

// >>> hw/frc_pkg.sv
// Package for the flash reset, width and sector-protect host controller
package frc_pkg;
  // ----------------------------------------------------------------------
  // Timing (clock 250 MHz)
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ          = 250;
  localparam int RST_PULSE_NS     = 500;   // Reset low time in read mode
  localparam int RST_BUSY_US      = 20;    // Longest internal reset after program/erase
  localparam int RST_RECOVER_NS   = 50;    // Wait after reset release before read
  localparam int PROT_PULSE_US    = 100;   // Protect strobe width
  localparam int UNPROT_PULSE_MS  = 10;    // Unprotect strobe width
  localparam int ACCESS_NS        = 120;   // Read access allowance
  localparam int SETUP_NS         = 50;    // Setup/hold around strobes
  localparam int RST_PULSE_CYC    = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int RST_BUSY_CYC     = RST_BUSY_US * CLK_MHZ;
  localparam int RST_RECOVER_CYC  = (RST_RECOVER_NS * CLK_MHZ + 999) / 1000;
  localparam int PROT_PULSE_CYC   = PROT_PULSE_US * CLK_MHZ;
  localparam int UNPROT_PULSE_CYC = UNPROT_PULSE_MS * 1000 * CLK_MHZ;
  localparam int ACCESS_CYC       = (ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int SETUP_CYC        = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W            = 24;

  // ----------------------------------------------------------------------
  // Register map (word addresses are byte offsets / 4)
  // ----------------------------------------------------------------------
  localparam logic [3:0] REG_CTRL   = 4'h0; // W: command start
  localparam logic [3:0] REG_ADDR   = 4'h1; // RW: address for access
  localparam logic [3:0] REG_WDATA  = 4'h2; // RW: write data
  localparam logic [3:0] REG_STATUS = 4'h3; // R: busy, done, pins
  localparam logic [3:0] REG_RDATA  = 4'h4; // R: read data
  localparam logic [3:0] REG_CFG    = 4'h5; // RW: word mode, power down
  localparam int CTRL_START   = 4;          // Bit that starts a command
  localparam int CFG_WORD     = 0;
  localparam int CFG_PDOWN    = 1;
  localparam int CFG_TEMP_UNP = 2;
  localparam int ST_BUSY      = 0;
  localparam int ST_DONE      = 1;
  localparam int ST_RDY       = 2;
  localparam int ST_PROT      = 3;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  // Addressed bits that select protect modes, and the lowest sector address bit
  localparam int A0_BIT = 0;
  localparam int A1_BIT = 1;
  localparam int A6_BIT = 6;
  localparam int SEC_LO = 12;

  // ----------------------------------------------------------------------
  // Commands
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    FRC_CMD_READ, FRC_CMD_WRITE, FRC_CMD_RESET, FRC_CMD_RESET_LONG,
    FRC_CMD_PROTECT, FRC_CMD_PROT_VERIFY, FRC_CMD_UNPROTECT, FRC_CMD_UNPROT_VERIFY
  } frc_cmd_t;

  // Flash pin bundle
  typedef struct packed {
    logic        chip_sel_n;
    logic        out_en_n;
    logic        write_n;
    logic        reset_n;
    logic        word_mode;
    logic        addr9_elevated;
    logic        out_en_elevated;
    logic        reset_elevated;
    logic [17:0] addr;
  } frc_pins_t;
endpackage : frc_pkg
